// file: logic/dma_chan_ctl.sv
// The register addresses and strobed register access are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "dma_chan_regs.svh"
module dma_chan_ctl
  import dma_chan_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [`REG_ADDR_W-1:0] reg_addr,
  input wire logic [`REG_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [`REG_DATA_W-1:0] reg_rdata,
  input wire logic irq_valid,
  input wire logic [7:0] irq_num,
  input wire logic xfer_active,
  input wire logic block_done,
  input wire logic pattern_match,
  input wire logic chain_done_lower,
  input wire logic chain_done_higher,
  input wire logic [7:0] evt_set,
  output logic chan_enable,
  output logic chan_busy_status,
  output logic [1:0] chan_priority,
  output logic start_req,
  output logic abort_req,
  output logic chan_irq
);

  ctl_state_t state_ff; // Registered channel state
  ctl_state_t nxt_state; // Next channel state

  chan_ev_if ev(); // Link to matcher and flag register

  // Register bus decode
  logic wr_ctl; // Write to channel control
  logic wr_econ; // Write to event control
  logic wr_int; // Write to interrupt control
  logic start_ev; // Start event this cycle
  logic abort_ev; // Abort event this cycle
  logic chain_src; // Selected neighbour completion
  logic accept_ev; // Events are recorded now
  logic [`REG_DATA_W-1:0] ctl_word; // Control register image
  logic [`REG_DATA_W-1:0] econ_word; // Event control image
  logic [`REG_DATA_W-1:0] int_word; // Interrupt control image

  assign wr_ctl = reg_wr & (reg_addr == `REG_CTL_OFS);
  assign wr_econ = reg_wr & (reg_addr == `REG_ECON_OFS);
  assign wr_int = reg_wr & (reg_addr == `REG_INT_OFS);

  // Configuration to the matcher
  assign ev.irq_valid = irq_valid;
  assign ev.irq_num = irq_num;
  assign ev.sirq_num = state_ff.sirq_num;
  assign ev.airq_num = state_ff.airq_num;
  assign ev.sirq_en = state_ff.sirq_en;
  assign ev.airq_en = state_ff.airq_en;

  // Traffic to the flag register
  assign ev.int_wr = wr_int;
  assign ev.int_wdata = reg_wdata;

  // Engine events plus our own abort raise flags
  always_comb begin
    ev.hw_set = evt_set;
    ev.hw_set[`INT_ABORT_FLAG_BIT] = evt_set[`INT_ABORT_FLAG_BIT] | state_ff.abort_pulse;
  end

  // Start and abort sources: matched interrupts and software writes
  assign start_ev = ev.start_hit | (wr_econ & reg_wdata[`ECON_FORCE_BIT]);
  assign abort_ev = ev.abort_hit | (wr_econ & reg_wdata[`ECON_ABORT_BIT]);

  // Events count while enabled, or always with the allow bit
  assign accept_ev = state_ff.chan_en | state_ff.allow_ev;

  // Neighbour completion chosen by direction bit
  assign chain_src = state_ff.chain_dir ? chain_done_lower : chain_done_higher;

  // Read images
  always_comb begin
    ctl_word = '0;
    ctl_word[`CTL_BUSY_BIT] = state_ff.busy;
    ctl_word[`CTL_CHNS_BIT] = state_ff.chain_dir;
    ctl_word[`CTL_EN_BIT] = state_ff.chan_en;
    ctl_word[`CTL_AED_BIT] = state_ff.allow_ev;
    ctl_word[`CTL_CHN_BIT] = state_ff.chain_en;
    ctl_word[`CTL_AEN_BIT] = state_ff.auto_en;
    ctl_word[`CTL_EDET_BIT] = state_ff.pend_start | state_ff.pend_abort;
    ctl_word[`CTL_PRI_MSB:`CTL_PRI_LSB] = state_ff.pri;
  end

  // Force and abort bits always read zero
  always_comb begin
    econ_word = '0;
    econ_word[`ECON_AIRQ_MSB:`ECON_AIRQ_LSB] = state_ff.airq_num;
    econ_word[`ECON_SIRQ_MSB:`ECON_SIRQ_LSB] = state_ff.sirq_num;
    econ_word[`ECON_PAT_BIT] = state_ff.pat_en;
    econ_word[`ECON_START_IRQ_ENABLE_BIT] = state_ff.sirq_en;
    econ_word[`ECON_ABORT_IRQ_ENABLE_BIT] = state_ff.airq_en;
  end

  // Interrupt register image
  always_comb begin
    int_word = '0;
    int_word[`INT_FLAG_MSB:`INT_FLAG_LSB] = ev.flags;
    int_word[`INT_EN_MSB:`INT_EN_LSB] = ev.en;
  end

  // Next state of the channel
  always_comb begin
    nxt_state = state_ff;
    nxt_state.start_pulse = 1'b0;
    nxt_state.abort_pulse = 1'b0;

    // Software writes to control
    if (wr_ctl) begin
      nxt_state.chain_dir = reg_wdata[`CTL_CHNS_BIT];
      nxt_state.chan_en = reg_wdata[`CTL_EN_BIT];
      nxt_state.allow_ev = reg_wdata[`CTL_AED_BIT];
      nxt_state.chain_en = reg_wdata[`CTL_CHN_BIT];
      nxt_state.auto_en = reg_wdata[`CTL_AEN_BIT];
      nxt_state.pri = reg_wdata[`CTL_PRI_MSB:`CTL_PRI_LSB];
    end

    // Software writes to event control
    if (wr_econ) begin
      nxt_state.airq_num = reg_wdata[`ECON_AIRQ_MSB:`ECON_AIRQ_LSB];
      nxt_state.sirq_num = reg_wdata[`ECON_SIRQ_MSB:`ECON_SIRQ_LSB];
      nxt_state.pat_en = reg_wdata[`ECON_PAT_BIT];
      nxt_state.sirq_en = reg_wdata[`ECON_START_IRQ_ENABLE_BIT];
      nxt_state.airq_en = reg_wdata[`ECON_ABORT_IRQ_ENABLE_BIT];
    end

    // Chaining enables the channel only when allowed
    if (state_ff.chain_en && chain_src) begin
      nxt_state.chan_en = 1'b1;
    end

    // Block completion drops enable unless auto enable
    if (block_done && !state_ff.auto_en) begin
      nxt_state.chan_en = 1'b0;
    end

    // Pending work is handed to the engine only while enabled
    if (state_ff.chan_en) begin
      if (state_ff.pend_abort) begin
        nxt_state.abort_pulse = 1'b1;
        nxt_state.pend_abort = 1'b0;
        nxt_state.pend_start = 1'b0;
      end else if (state_ff.pend_start) begin
        nxt_state.start_pulse = 1'b1;
        nxt_state.pend_start = 1'b0;
      end
    end

    // New events recorded; abort cancels a waiting start
    if (accept_ev) begin
      if (abort_ev) begin
        nxt_state.pend_abort = 1'b1;
        nxt_state.pend_start = 1'b0;
      end else if (start_ev) begin
        nxt_state.pend_start = 1'b1;
      end
    end

    // Pattern match aborts at once and disables
    if (state_ff.pat_en && pattern_match && (state_ff.chan_en || xfer_active)) begin
      nxt_state.abort_pulse = 1'b1;
      nxt_state.start_pulse = 1'b0;
      nxt_state.pend_start = 1'b0;
      nxt_state.chan_en = 1'b0;
    end

    // Busy until disabled and the engine has stopped
    nxt_state.busy = nxt_state.chan_en | xfer_active;

    // Read data valid only in the cycle after the strobe
    nxt_state.rdata = '0;
    if (reg_rd) begin
      unique case (reg_addr)
        `REG_CTL_OFS: nxt_state.rdata = ctl_word;
        `REG_ECON_OFS: nxt_state.rdata = econ_word;
        `REG_INT_OFS: nxt_state.rdata = int_word;
        default: nxt_state.rdata = '0;
      endcase
    end
  end

  // State register with documented reset values
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_ff <= '0;
      state_ff.airq_num <= `ECON_IRQ_RST;
      state_ff.sirq_num <= `ECON_IRQ_RST;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Interrupt number matcher
  irq_trigger u_trig (
    .mclk(mclk),
    .rst(rst),
    .ev(ev.trig)
  );

  // Flag and enable register
  int_flags u_int (
    .mclk(mclk),
    .rst(rst),
    .ev(ev.intr)
  );

  // Outputs straight from flops
  assign reg_rdata = state_ff.rdata;
  assign chan_enable = state_ff.chan_en;
  assign chan_busy_status = state_ff.busy;
  assign chan_priority = state_ff.pri;
  assign start_req = state_ff.start_pulse;
  assign abort_req = state_ff.abort_pulse;
  assign chan_irq = ev.irq;

endmodule
`default_nettype wire

// file: logic/dma_chan_regs.svh
`ifndef DMA_CHAN_REGS_SVH
`define DMA_CHAN_REGS_SVH

// Register bus geometry
`define REG_ADDR_W 4
`define REG_DATA_W 32

// Register word byte addresses
`define REG_CTL_OFS 4'h0
`define REG_ECON_OFS 4'h4
`define REG_INT_OFS 4'h8

// Channel control register fields
`define CTL_BUSY_BIT 15
`define CTL_CHNS_BIT 8
`define CTL_EN_BIT 7
`define CTL_AED_BIT 6
`define CTL_CHN_BIT 5
`define CTL_AEN_BIT 4
`define CTL_EDET_BIT 2
`define CTL_PRI_MSB 1
`define CTL_PRI_LSB 0

// Event control register fields
`define ECON_AIRQ_MSB 23
`define ECON_AIRQ_LSB 16
`define ECON_SIRQ_MSB 15
`define ECON_SIRQ_LSB 8
`define ECON_FORCE_BIT 7
`define ECON_ABORT_BIT 6
`define ECON_PAT_BIT 5
`define ECON_START_IRQ_ENABLE_BIT 4
`define ECON_ABORT_IRQ_ENABLE_BIT 3
`define ECON_IRQ_RST 8'hff

// Interrupt control register fields
`define INT_FLAG_MSB 7
`define INT_FLAG_LSB 0
`define INT_EN_MSB 23
`define INT_EN_LSB 16
`define INT_ABORT_FLAG_BIT 1
`define INT_SRC_DONE_BIT 7

`endif

// file: logic/dma_chan_pkg.sv
package dma_chan_pkg;

  // Whole state of the channel control block
  typedef struct packed {
    logic chan_en;           // Channel runs while set
    logic chain_dir;         // Chain source: 1 lower, 0 higher priority
    logic allow_ev;          // Keep events while disabled
    logic chain_en;          // Neighbour completion may enable
    logic auto_en;           // Stay enabled after block completion
    logic [1:0] pri;         // Arbitration priority
    logic busy;              // Enabled or still moving data
    logic pend_start;        // Start event waiting
    logic pend_abort;        // Abort event waiting
    logic pat_en;            // Pattern match abort enable
    logic sirq_en;           // Start by interrupt enable
    logic airq_en;           // Abort by interrupt enable
    logic [7:0] sirq_num;    // Start interrupt number
    logic [7:0] airq_num;    // Abort interrupt number
    logic start_pulse;       // Start request to engine
    logic abort_pulse;       // Abort request to engine
    logic [31:0] rdata;      // Read data word
  } ctl_state_t;

  // State of the interrupt number matcher
  typedef struct packed {
    logic start_hit;         // Start number seen
    logic abort_hit;         // Abort number seen
  } trig_state_t;

  // State of the interrupt flag register
  typedef struct packed {
    logic [7:0] flags;       // Event flags
    logic [7:0] en;          // Per flag enables
    logic irq;               // Request to interrupt controller
  } int_state_t;

endpackage

// file: logic/chan_ev_if.sv
`timescale 1ns/1ps
`default_nettype none
// Carries triggers and interrupt register traffic inside the channel
interface chan_ev_if;
  logic irq_valid;       // Interrupt event this cycle
  logic [7:0] irq_num;   // Its number
  logic [7:0] sirq_num;  // Selected start number
  logic [7:0] airq_num;  // Selected abort number
  logic sirq_en;         // Start match enabled
  logic airq_en;         // Abort match enabled
  logic start_hit;       // Start number matched
  logic abort_hit;       // Abort number matched
  logic int_wr;          // Write to interrupt register
  logic [31:0] int_wdata;// Its data
  logic [7:0] hw_set;    // Hardware flag set pulses
  logic [7:0] flags;     // Current flags
  logic [7:0] en;        // Current enables
  logic irq;             // Combined interrupt request

  modport ctl (output irq_valid, irq_num, sirq_num, airq_num, sirq_en, airq_en,
               int_wr, int_wdata, hw_set,
               input start_hit, abort_hit, flags, en, irq);
  modport trig (input irq_valid, irq_num, sirq_num, airq_num, sirq_en, airq_en,
                output start_hit, abort_hit);
  modport intr (input int_wr, int_wdata, hw_set, output flags, en, irq);
endinterface
`default_nettype wire

// file: logic/irq_trigger.sv
`timescale 1ns/1ps
`default_nettype none
`include "dma_chan_regs.svh"
module irq_trigger
  import dma_chan_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  chan_ev_if.trig ev
);

  trig_state_t state_ff; // Registered hits
  trig_state_t nxt_state; // Next hits

  // Compare incoming interrupt against selected numbers
  always_comb begin
    nxt_state = '0;
    nxt_state.start_hit = ev.irq_valid & ev.sirq_en & (ev.irq_num == ev.sirq_num);
    nxt_state.abort_hit = ev.irq_valid & ev.airq_en & (ev.irq_num == ev.airq_num);
  end

  // State register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign ev.start_hit = state_ff.start_hit;
  assign ev.abort_hit = state_ff.abort_hit;

endmodule
`default_nettype wire

// file: logic/int_flags.sv
`timescale 1ns/1ps
`default_nettype none
`include "dma_chan_regs.svh"
module int_flags
  import dma_chan_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  chan_ev_if.intr ev
);

  int_state_t state_ff; // Flags, enables, request
  int_state_t nxt_state; // Next copy

  // Software write, then hardware sets on top so a set beats a clear
  always_comb begin
    nxt_state = state_ff;
    if (ev.int_wr) begin
      nxt_state.flags = ev.int_wdata[`INT_FLAG_MSB:`INT_FLAG_LSB];
      nxt_state.en = ev.int_wdata[`INT_EN_MSB:`INT_EN_LSB];
    end
    nxt_state.flags = nxt_state.flags | ev.hw_set;
    nxt_state.irq = |(nxt_state.flags & nxt_state.en);
  end

  // State register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign ev.flags = state_ff.flags;
  assign ev.en = state_ff.en;
  assign ev.irq = state_ff.irq;

endmodule
`default_nettype wire

// file: dv/dma_chan_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "dma_chan_regs.svh"
// Watches the channel ports beside a shadow of software writes
module dma_chan_sva (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic irq_valid,
  input wire logic [7:0] irq_num,
  input wire logic xfer_active,
  input wire logic block_done,
  input wire logic pattern_match,
  input wire logic chain_done_lower,
  input wire logic chain_done_higher,
  input wire logic [7:0] evt_set,
  input wire logic chan_enable,
  input wire logic chan_busy_status,
  input wire logic [1:0] chan_priority,
  input wire logic start_req,
  input wire logic abort_req,
  input wire logic chan_irq
);
  logic [8:0] ctl_ff; // Written control bits
  logic [7:0] econ_ff; // Written event control low byte
  logic [7:0] ien_ff; // Written interrupt enables
  // Shadow of the last software writes
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctl_ff <= 9'h0;
      econ_ff <= 8'h0;
      ien_ff <= 8'h0;
    end else if (reg_wr) begin
      if (reg_addr == `REG_CTL_OFS) ctl_ff <= reg_wdata[8:0];
      if (reg_addr == `REG_ECON_OFS) econ_ff <= reg_wdata[7:0];
      if (reg_addr == `REG_INT_OFS) ien_ff <= reg_wdata[23:16];
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  a_busy_while_on: assert property (chan_enable && xfer_active |=> chan_busy_status)
    else $error("busy low while channel on");
  a_ctl_unused_zero: assert property ($past(reg_rd && reg_addr == `REG_CTL_OFS) |->
    reg_rdata[31:16] == 16'h0 && reg_rdata[14:9] == 6'h0 && !reg_rdata[3])
    else $error("unused control bits not zero");
  a_strobe_bits_zero: assert property ($past(reg_rd && reg_addr == `REG_ECON_OFS) |->
    reg_rdata[7:6] == 2'h0)
    else $error("force or abort bit reads one");
  a_start_needs_en: assert property (start_req |-> $past(chan_enable))
    else $error("start while disabled");
  a_prio_write: assert property ($past(reg_wr && reg_addr == `REG_CTL_OFS) |->
    chan_priority == $past(reg_wdata[1:0]))
    else $error("priority not as written");
  a_pattern_kill: assert property (pattern_match && econ_ff[5] && chan_enable && !reg_wr
    |=> abort_req && !chan_enable)
    else $error("pattern match did not abort");
  a_irq_on_flag: assert property ((|(evt_set & ien_ff)) && !reg_wr |=> chan_irq)
    else $error("enabled flag without request");
  a_block_off: assert property (block_done && !ctl_ff[4] && !reg_wr && !chain_done_lower
    && !chain_done_higher |=> !chan_enable)
    else $error("enable kept after block");
  a_chain_pick: assert property (ctl_ff[5] && !reg_wr && !pattern_match && !block_done &&
    (ctl_ff[8] ? chain_done_lower : chain_done_higher) |=> chan_enable)
    else $error("chain did not enable");
  a_chain_gate: assert property (!chan_enable && !ctl_ff[5] && !reg_wr |=> !chan_enable)
    else $error("enabled without write or chain");
  c_start: cover property (start_req);
  c_abort: cover property (abort_req);
  c_irq: cover property (chan_irq);
  c_drain: cover property (chan_busy_status && !chan_enable);
endmodule
bind dma_chan_ctl dma_chan_sva chk_i (.mclk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .irq_valid, .irq_num, .xfer_active, .block_done, .pattern_match,
  .chain_done_lower, .chain_done_higher, .evt_set, .chan_enable, .chan_busy_status,
  .chan_priority, .start_req, .abort_req, .chan_irq);
`default_nettype wire

// file: dv/engine_model.sv
`timescale 1ns/1ps
`default_nettype none
// Data engine stand-in: runs len cycles per start, stops on abort
module engine_model (
  input wire logic mclk,
  input wire logic rst,
  input wire logic start_req,
  input wire logic abort_req,
  input wire logic [3:0] len,
  output logic xfer_active,
  output logic block_done
);
  logic [3:0] left_ff; // Cycles left in the running block
  assign xfer_active = left_ff != 4'h0;
  // Count down the block, report completion once
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      left_ff <= 4'h0;
      block_done <= 1'b0;
    end else begin
      block_done <= left_ff == 4'h1 && !abort_req && !start_req;
      if (abort_req) left_ff <= 4'h0;
      else if (start_req) left_ff <= len;
      else if (left_ff != 4'h0) left_ff <= left_ff - 4'h1;
    end
  end
endmodule
`default_nettype wire

// file: dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "dma_chan_regs.svh"
module tb_top;
  logic mclk, rst, reg_wr, reg_rd, irq_valid, pattern_match, chain_done_lower, chain_done_higher;
  logic [3:0] reg_addr, len;
  logic [31:0] reg_wdata, reg_rdata, rnd;
  logic [7:0] irq_num, evt_set, snum, anum;
  logic [1:0] pri, chan_priority;
  logic rd_p; // Read strobe taken at the last edge
  logic xfer_active, block_done, chan_enable, chan_busy_status, start_req, abort_req, chan_irq;
  logic [31:0] exp_q[$], msk_q[$]; // Expected read words and masks
  logic [1:0] ev_q[$]; // Expected pulses: 1 start, 2 abort
  int n_fail, cmp_count, seed, i;
  dma_chan_ctl dut (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_valid(irq_valid),
    .irq_num(irq_num), .xfer_active(xfer_active), .block_done(block_done),
    .pattern_match(pattern_match), .chain_done_lower(chain_done_lower),
    .chain_done_higher(chain_done_higher), .evt_set(evt_set), .chan_enable(chan_enable),
    .chan_busy_status(chan_busy_status), .chan_priority(chan_priority),
    .start_req(start_req), .abort_req(abort_req), .chan_irq(chan_irq));
  engine_model eng (.mclk(mclk), .rst(rst), .start_req(start_req), .abort_req(abort_req),
    .len(len), .xfer_active(xfer_active), .block_done(block_done));
  // Clock at 4 ns
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    cmp_count++;
    if (s !== e) begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, e, s);
    end
  endtask
  task finish_test;
    if (n_fail == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
  endtask
  task irq(input logic [7:0] n);
    @(posedge mclk);
    irq_valid <= 1'b1;
    irq_num <= n;
    @(posedge mclk);
    irq_valid <= 1'b0;
  endtask
  // Read data stands in the cycle after the strobe
  always @(posedge mclk) rd_p <= reg_rd;
  // Take the oldest note for every result that shows
  always @(negedge mclk) begin
    if (rd_p) chk("rdata", exp_q.pop_front(), reg_rdata & msk_q.pop_front());
    if (start_req === 1'b1 || abort_req === 1'b1) begin
      if (ev_q.size() == 0) chk("pulse", 32'h0, {30'h0, abort_req, start_req});
      else chk("pulse", {30'h0, ev_q.pop_front()}, {30'h0, abort_req, start_req});
    end
  end
  // Hang guard
  initial begin
    tick(20000);
    n_fail++;
    finish_test();
  end
  // Main sequence
  initial begin
    {reg_wr, reg_rd, irq_valid, pattern_match, chain_done_lower, chain_done_higher} = 6'h0;
    {reg_addr, reg_wdata, irq_num, evt_set} = '0;
    seed = 32'h2d97b53e;
    rnd = $random(seed);
    {len, pri, snum} = {4'h1 + {1'b0, rnd[18:16]}, rnd[9:8], rnd[7:0]};
    anum = ~snum;
    rst = 1'b1;
    tick(8);
    rst <= 1'b0;
    rd(`REG_CTL_OFS, 32'h0, 32'hffffffff);
    rd(`REG_ECON_OFS, 32'h00ffff00, 32'hffffffff);
    rd(`REG_INT_OFS, 32'h0, 32'hffffffff);
    rd(4'hc, 32'h0, 32'hffffffff);
    wr(`REG_ECON_OFS, {8'h0, anum, snum, 8'hd8});
    rd(`REG_ECON_OFS, {8'h0, anum, snum, 8'h18}, 32'hffffffff);
    rd(`REG_CTL_OFS, 32'h0, 32'hffffffff);
    wr(`REG_CTL_OFS, {24'h0, 8'h80 | {6'h0, pri}});
    rd(`REG_CTL_OFS, {16'h8080 | {14'h0, pri}}, 32'hffffffff);
    chk("prio", {30'h0, pri}, {30'h0, chan_priority});
    irq(snum ^ 8'h01);
    tick(4);
    ev_q.push_back(2'h1);
    irq(snum);
    for (i = 0; i < 60 && chan_busy_status !== 1'b0; i++) @(posedge mclk);
    chk("busy_clear", 32'h0, {31'h0, chan_busy_status});
    rd(`REG_CTL_OFS, {30'h0, pri}, 32'hffffffff);
    wr(`REG_CTL_OFS, {24'h0, 8'h40 | {6'h0, pri}});
    irq(snum);
    tick(4);
    rd(`REG_CTL_OFS, {24'h0, 8'h44 | {6'h0, pri}}, 32'hffffffff);
    ev_q.push_back(2'h1);
    wr(`REG_CTL_OFS, {24'h0, 8'h90 | {6'h0, pri}});
    tick(4);
    ev_q.push_back(2'h2);
    irq(anum);
    tick(4);
    ev_q.push_back(2'h1);
    wr(`REG_ECON_OFS, {8'h0, anum, snum, 8'h98});
    tick(14);
    chk("auto_en", 32'h1, {31'h0, chan_enable});
    ev_q.push_back(2'h2);
    wr(`REG_ECON_OFS, {8'h0, anum, snum, 8'h58});
    tick(4);
    wr(`REG_ECON_OFS, {8'h0, anum, snum, 8'h08});
    irq(snum);
    tick(4);
    wr(`REG_ECON_OFS, {8'h0, anum, snum, 8'h20});
    ev_q.push_back(2'h2);
    @(posedge mclk);
    pattern_match <= 1'b1;
    @(posedge mclk);
    pattern_match <= 1'b0;
    tick(3);
    chk("pattern_off", 32'h0, {31'h0, chan_enable});
    for (i = 0; i < 6; i++) begin
      wr(`REG_CTL_OFS, {23'h0, (i < 2) ? 9'h120 : (i < 4) ? 9'h020 : 9'h100});
      @(posedge mclk);
      chain_done_lower <= i inside {0, 3, 4};
      chain_done_higher <= !(i inside {0, 3, 4});
      @(posedge mclk);
      {chain_done_lower, chain_done_higher} <= 2'h0;
      tick(2);
      chk("chain", {31'h0, i inside {0, 2}}, {31'h0, chan_enable});
    end
    wr(`REG_INT_OFS, 32'h00800000);
    @(posedge mclk);
    evt_set <= 8'h80 | (rnd[31:24] & 8'h7c);
    @(posedge mclk);
    evt_set <= 8'h00;
    tick(1);
    chk("irq_on", 32'h1, {31'h0, chan_irq});
    rd(`REG_INT_OFS, 32'h00800080 | {24'h0, rnd[31:24] & 8'h7c}, 32'hfffffffd);
    wr(`REG_INT_OFS, 32'h0);
    tick(2);
    chk("irq_off", 32'h0, {31'h0, chan_irq});
    tick(4);
    chk("pulses_left", 32'h0, ev_q.size());
    finish_test();
  end
endmodule
`default_nettype wire
